// File: hdl/ptm_pkg.sv
// package with register map, field positions and constants for the periodic timer
package ptm_pkg;
   localparam logic [4:0] PTM_OFS_CONTROL_A   = 5'h00;
   localparam logic [4:0] PTM_OFS_CONTROL_B   = 5'h04;
   localparam logic [4:0] PTM_OFS_COUNT_LOW   = 5'h08;
   localparam logic [4:0] PTM_OFS_COUNT_HIGH  = 5'h0c;
   localparam logic [4:0] PTM_OFS_CMP_A_LOW   = 5'h10;
   localparam logic [4:0] PTM_OFS_CMP_A_HIGH  = 5'h14;
   localparam logic [4:0] PTM_OFS_PERIOD_LOW  = 5'h18;
   localparam logic [4:0] PTM_OFS_PERIOD_HIGH = 5'h1c;
   localparam logic [4:0] PTM_OFS_FLAGS       = 5'h00;
   localparam logic [7:0] PTM_OFS_FLAGS_FULL  = 8'h20;
   localparam int PTM_CA_PAUSE      = 7;
   localparam int PTM_CA_CLK_HI     = 6;
   localparam int PTM_CA_CLK_LO     = 4;
   localparam int PTM_CA_RUN        = 3;
   localparam int PTM_CB_MODE_HI    = 7;
   localparam int PTM_CB_MODE_LO    = 6;
   localparam int PTM_CB_PIN_HI     = 5;
   localparam int PTM_CB_PIN_LO     = 4;
   localparam int PTM_CB_LEVEL      = 3;
   localparam int PTM_CB_INVERT     = 2;
   localparam int PTM_CB_CLEAR_SEL  = 0;
   localparam logic [7:0] PTM_CA_MASK   = 8'hf8;
   localparam logic [7:0] PTM_CB_MASK   = 8'hfd;
   localparam logic [7:0] PTM_RESET_VAL = 8'h00;
   localparam logic [1:0] PTM_MODE_COMPARE = 2'b00;
   localparam logic [1:0] PTM_MODE_PWM     = 2'b10;
   localparam logic [1:0] PTM_MODE_TIMER   = 2'b11;
   localparam logic [2:0] PTM_CLK_SYS_DIV4 = 3'b000;
   localparam logic [2:0] PTM_CLK_SYS      = 3'b001;
   localparam logic [2:0] PTM_CLK_HIGH_16  = 3'b010;
   localparam logic [2:0] PTM_CLK_HIGH_64  = 3'b011;
   localparam logic [2:0] PTM_CLK_EXT_RISE = 3'b110;
   localparam logic [2:0] PTM_CLK_EXT_FALL = 3'b111;
   localparam logic [9:0] PTM_COUNT_MAX = 10'h3ff;
   localparam logic [1:0] PTM_RESP_OKAY   = 2'b00;
   localparam logic [1:0] PTM_RESP_SLVERR = 2'b10;
endpackage : ptm_pkg

// File: hdl/ptm_timer.sv
// periodic timer module with axi4-lite register slave
// What this block does
// - ten-bit up-counter advances once per tick of the selected clock source
// - comparators A and P match counter against compare-A and period values
// - counter not writable; clears on overflow or selected comparator match
// - pause bit 7 set holds the count; clearing resumes from held value
// - clock select picks system/4, system, high/16, high/64, sub, external edges
// - run enables counting; off retains count; rising run zeroes the counter
// - rising run returns the pin to initial level in output modes
// - mode 00 compare, 01 undefined, 10 pwm or single pulse, 11 timer
// - compare mode A match: 00 keep, 01 low, 10 high, 11 toggle
// - pwm mode pin bits: 00 inactive, 01 active, 10 pwm, 11 single pulse
// - requested level equal to initial level gives no visible pin change
// - level bit sets initial level, pwm polarity, single pulse start level
// - invert bit 2 inverts the output pin, no effect in timer mode
// - clear select 1 clears on A match, 0 on P match or overflow
// - count readable as byte pair; compare values read/write byte pairs
// - timer mode output level is undefined, output need not be driven
// - second output always the inverse of the primary output
// - unimplemented high bits and control a bits 2..0 read zero
// - clear on A raises only A flag; A zero overflows at 3ff flagless
// - pwm period from period value, zero is 1024; duty at/above period full
// - single pulse: A match clears run; external active edge sets run
`timescale 1ns/1ps
module ptm_timer
   import ptm_pkg::*;
#(
   parameter int HIGH_DIV_A = 16,
   parameter int HIGH_DIV_B = 64
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        high_clock_tick,
   input  wire logic        sub_clock_tick,
   input  wire logic        external_clock_input,
   output logic             timer_output,
   output logic             timer_output_inverted,
   output logic             compare_a_flag,
   output logic             compare_p_flag,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic [7:0] timer_control_a;
   logic [7:0] timer_control_b;
   logic [9:0] compare_a_value;
   logic [9:0] period_compare_value;
   logic [9:0] count;
   logic       run_prev;
   logic       ext_prev;
   logic       pin_level;
   logic [1:0] sys_div;
   logic [5:0] high_div;
   logic [7:0] aw_addr;
   logic       aw_held;
   logic [31:0] w_data;
   logic       w_lane0;
   logic       w_held;

   logic       timer_run;
   logic       count_pause;
   logic [2:0] clock_source_select;
   logic [1:0] operating_mode_select;
   logic [1:0] pin_function_select;
   logic       output_level_control;
   logic       output_invert;
   logic       clear_source_select;
   logic       tick;
   logic       ext_rise;
   logic       ext_fall;
   logic       run_rise;
   logic       match_a;
   logic       match_p;
   logic       overflow;
   logic       clear_count;
   logic       pulse_mode;
   logic       pulse_end;
   logic       pulse_start;
   logic       wr_fire;
   logic       wr_ok;
   logic [9:0] next_count;
   logic       next_pin;

   assign timer_run             = timer_control_a[PTM_CA_RUN];
   assign count_pause           = timer_control_a[PTM_CA_PAUSE];
   assign clock_source_select   = timer_control_a[PTM_CA_CLK_HI:PTM_CA_CLK_LO];
   assign operating_mode_select = timer_control_b[PTM_CB_MODE_HI:PTM_CB_MODE_LO];
   assign pin_function_select   = timer_control_b[PTM_CB_PIN_HI:PTM_CB_PIN_LO];
   assign output_level_control  = timer_control_b[PTM_CB_LEVEL];
   assign output_invert         = timer_control_b[PTM_CB_INVERT];
   assign clear_source_select   = timer_control_b[PTM_CB_CLEAR_SEL];
   assign ext_rise = external_clock_input & ~ext_prev;
   assign ext_fall = ~external_clock_input & ext_prev;
   assign run_rise = timer_run & ~run_prev;
   assign pulse_mode = (operating_mode_select == PTM_MODE_PWM) && (pin_function_select == 2'b11);

   // internal divided ticks run freely
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sys_div <= 2'h0;
      end else begin
         sys_div <= sys_div + 2'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         high_div <= 6'h00;
      end else if (high_clock_tick) begin
         high_div <= high_div + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         ext_prev <= external_clock_input;
         run_prev <= timer_run;
      end
   end

   // source selection
   always_comb begin
      unique case (clock_source_select)
         PTM_CLK_SYS_DIV4: tick = (sys_div == 2'h3);
         PTM_CLK_SYS:      tick = 1'b1;
         PTM_CLK_HIGH_16:  tick = high_clock_tick && (high_div[3:0] == 4'(HIGH_DIV_A - 1));
         PTM_CLK_HIGH_64:  tick = high_clock_tick && (high_div == 6'(HIGH_DIV_B - 1));
         PTM_CLK_EXT_RISE: tick = ext_rise;
         PTM_CLK_EXT_FALL: tick = ext_fall;
         default:          tick = sub_clock_tick;
      endcase
   end

   // comparators, evaluated on the tick that reaches the value
   assign match_a = tick && timer_run && !count_pause && (count + 10'h001 == compare_a_value)
                    && (compare_a_value != 10'h000);
   assign match_p = tick && timer_run && !count_pause && (count + 10'h001 == period_compare_value)
                    && (period_compare_value != 10'h000);
   assign overflow = tick && timer_run && !count_pause && (count == PTM_COUNT_MAX);

   always_comb begin
      if (operating_mode_select == PTM_MODE_PWM) begin
         clear_count = match_p || overflow;
      end else if (clear_source_select) begin
         clear_count = match_a || overflow;
      end else begin
         clear_count = match_p || overflow;
      end
   end

   assign pulse_end   = pulse_mode && match_a;
   assign pulse_start = pulse_mode && !timer_run && (clock_source_select == PTM_CLK_EXT_FALL ? ext_fall : ext_rise);

   always_comb begin
      next_count = count;
      if (run_rise) begin
         next_count = 10'h000;
      end else if (timer_run && !count_pause && tick) begin
         next_count = clear_count ? 10'h000 : 10'(count + 10'h001);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= 10'h000;
      end else begin
         count <= next_count;
      end
   end

   // sticky flags; set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
      end else begin
         compare_a_flag <= match_a | (compare_a_flag &
            ~(wr_fire && aw_addr == PTM_OFS_FLAGS_FULL && w_lane0 && w_data[0]));
         compare_p_flag <= (match_p && !(clear_source_select && operating_mode_select != PTM_MODE_PWM))
            | (compare_p_flag & ~(wr_fire && aw_addr == PTM_OFS_FLAGS_FULL && w_lane0 && w_data[1]));
      end
   end

   // pin level before inversion
   always_comb begin
      next_pin = pin_level;
      if (run_rise) begin
         next_pin = output_level_control;
      end else if (operating_mode_select == PTM_MODE_COMPARE) begin
         if (match_a) begin
            unique case (pin_function_select)
               2'b00: next_pin = pin_level;
               2'b01: next_pin = 1'b0;
               2'b10: next_pin = 1'b1;
               2'b11: next_pin = ~pin_level;
            endcase
         end
      end else if (operating_mode_select == PTM_MODE_PWM) begin
         unique case (pin_function_select)
            2'b00: next_pin = ~output_level_control;
            2'b01: next_pin = output_level_control;
            2'b10: next_pin = ((next_count < compare_a_value) || (period_compare_value != 10'h000 &&
                   compare_a_value >= period_compare_value)) ? output_level_control : ~output_level_control;
            2'b11: next_pin = (timer_run && !pulse_end) ? output_level_control : ~output_level_control;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_level <= 1'b0;
      end else begin
         pin_level <= next_pin;
      end
   end

   // timer mode leaves the pin at its last level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_output          <= 1'b0;
         timer_output_inverted <= 1'b1;
      end else if (operating_mode_select != PTM_MODE_TIMER) begin
         timer_output          <= next_pin ^ output_invert;
         timer_output_inverted <= ~(next_pin ^ output_invert);
      end
   end

   // axi4-lite write path
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok   = (aw_addr[1:0] == 2'b00) && (aw_addr <= PTM_OFS_FLAGS_FULL);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_held  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         w_data  <= s_axi_wdata;
         w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PTM_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? PTM_RESP_OKAY : PTM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register stores; count has no write path
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_a <= PTM_RESET_VAL;
      end else if (pulse_end) begin
         timer_control_a[PTM_CA_RUN] <= 1'b0;
      end else if (pulse_start) begin
         timer_control_a[PTM_CA_RUN] <= 1'b1;
      end else if (wr_fire && w_lane0 && aw_addr == {3'h0, PTM_OFS_CONTROL_A}) begin
         timer_control_a <= w_data[7:0] & PTM_CA_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_b      <= PTM_RESET_VAL;
         compare_a_value      <= 10'h000;
         period_compare_value <= 10'h000;
      end else if (wr_fire && w_lane0) begin
         unique case (aw_addr)
            {3'h0, PTM_OFS_CONTROL_B}:   timer_control_b <= w_data[7:0] & PTM_CB_MASK;
            {3'h0, PTM_OFS_CMP_A_LOW}:   compare_a_value[7:0] <= w_data[7:0];
            {3'h0, PTM_OFS_CMP_A_HIGH}:  compare_a_value[9:8] <= w_data[1:0];
            {3'h0, PTM_OFS_PERIOD_LOW}:  period_compare_value[7:0] <= w_data[7:0];
            {3'h0, PTM_OFS_PERIOD_HIGH}: period_compare_value[9:8] <= w_data[1:0];
            default: ;
         endcase
      end
   end

   // axi4-lite read path
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= PTM_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= PTM_RESP_OKAY;
            unique case (s_axi_araddr)
               {3'h0, PTM_OFS_CONTROL_A}:   s_axi_rdata <= {24'h0, timer_control_a};
               {3'h0, PTM_OFS_CONTROL_B}:   s_axi_rdata <= {24'h0, timer_control_b};
               {3'h0, PTM_OFS_COUNT_LOW}:   s_axi_rdata <= {24'h0, count[7:0]};
               {3'h0, PTM_OFS_COUNT_HIGH}:  s_axi_rdata <= {30'h0, count[9:8]};
               {3'h0, PTM_OFS_CMP_A_LOW}:   s_axi_rdata <= {24'h0, compare_a_value[7:0]};
               {3'h0, PTM_OFS_CMP_A_HIGH}:  s_axi_rdata <= {30'h0, compare_a_value[9:8]};
               {3'h0, PTM_OFS_PERIOD_LOW}:  s_axi_rdata <= {24'h0, period_compare_value[7:0]};
               {3'h0, PTM_OFS_PERIOD_HIGH}: s_axi_rdata <= {30'h0, period_compare_value[9:8]};
               PTM_OFS_FLAGS_FULL:          s_axi_rdata <= {30'h0, compare_p_flag, compare_a_flag};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= PTM_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : ptm_timer

// File: test/ptm_assertions.sv
// checker for bus handshakes, sticky flags and the output pair
`timescale 1ns/1ps
module ptm_checker
   import ptm_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        timer_output,
   input wire logic        timer_output_inverted,
   input wire logic        compare_a_flag,
   input wire logic        compare_p_flag,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic [2:0] quiet;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // cycles since the last write request, so flag clears are excused
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) quiet <= 3'h0;
      else if (s_axi_wvalid || s_axi_awvalid) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   end
   inv_pair_a: assert property (timer_output_inverted == !timer_output)
      else $error("inverted output is not the complement");
   aflag_hold_a: assert property (compare_a_flag && quiet > 3'h3 |=> compare_a_flag)
      else $error("a flag dropped without a write");
   pflag_hold_a: assert property (compare_p_flag && quiet > 3'h3 |=> compare_p_flag)
      else $error("p flag dropped without a write");
   rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above the byte not zero");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
endmodule : ptm_checker
bind ptm_timer ptm_checker ptm_checker_i (.clk_sys(clk_sys), .rst_n(rst_n), .timer_output(timer_output),
   .timer_output_inverted(timer_output_inverted), .compare_a_flag(compare_a_flag),
   .compare_p_flag(compare_p_flag), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// File: test/ptm_pin_model.sv
// far-side pin model: external clock source; output pins are wired in but not observed
`timescale 1ns/1ps
module ptm_pin_model
   import ptm_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic timer_output,
   input  wire logic timer_output_inverted,
   output logic      external_clock_input
);
   initial external_clock_input = 1'b0;
   // n pulses, each level held h cycles; the pin rests low between bursts
   task automatic pulses(input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge clk_sys);
         external_clock_input <= 1'b1;
         repeat (h) @(posedge clk_sys);
         external_clock_input <= 1'b0;
      end
      repeat (h) @(posedge clk_sys);
   endtask : pulses
endmodule : ptm_pin_model

// File: test/testbench.sv
// self-checking bench: bus tasks, counter model and pin model
`timescale 1ns/1ps
module testbench
   import ptm_pkg::*;
;
   logic        clk_sys;
   logic        rst_n = 1'b0;
   logic        high_clock_tick = 1'b0;
   logic        sub_clock_tick = 1'b0;
   logic        ext_in;
   logic        t_out;
   logic        t_inv;
   logic        fa;
   logic        fp;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, bresp_seen, rresp_seen;
   logic [31:0] rdata;
   int          seed = 32'hd080;
   int          errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          rv;
   int          m_cnt, m_pin, m_fa, m_fp, m_a, m_p, m_io, m_lvl, m_inv, m_csel;
   logic [7:0]  cfg_b [5] = '{8'h31, 8'h24, 8'h18, 8'h10, 8'h01};
   logic [2:0]  cfg_s [5] = '{3'b110, 3'b111, 3'b110, 3'b111, 3'b110};
   int          cfg_a [5] = '{5, 2, 3, 3, 2};
   int          cfg_p [5] = '{0, 4, 7, 0, 0};
   ptm_timer ptm_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .high_clock_tick(high_clock_tick),
      .sub_clock_tick(sub_clock_tick), .external_clock_input(ext_in), .timer_output(t_out),
      .timer_output_inverted(t_inv), .compare_a_flag(fa), .compare_p_flag(fp),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   ptm_pin_model ptm_pin_model_i (.clk_sys(clk_sys), .timer_output(t_out), .timer_output_inverted(t_inv),
      .external_clock_input(ext_in));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      rv = $random(seed);
      high_clock_tick <= rv[0];
      sub_clock_tick <= rv[1];
      if (cycles == 60000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   function automatic int lag();
      return $unsigned($random(seed)) % 3;
   endfunction : lag
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(ad && dd));
      repeat (lag()) @(posedge clk_sys);
      bready <= 1'b1;
      do @(posedge clk_sys); while (!bvalid);
      bresp_seen = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      repeat (lag()) @(posedge clk_sys);
      rready <= 1'b1;
      do @(posedge clk_sys); while (!rvalid);
      d = rdata;
      rresp_seen = rresp;
      rready <= 1'b0;
   endtask : rd
   // counter model: one loop pass per active external clock edge, n passes per call
   task automatic step(input int n);
      repeat (n) begin
         m_cnt = m_cnt + 1;
         if (m_cnt == m_a) begin
            m_fa = 1;
            m_pin = (m_io == 3) ? 1 - m_pin : (m_io == 2) ? 1 : (m_io == 1) ? 0 : m_pin;
            if (m_csel == 1) m_cnt = 0;
         end
         if (m_csel == 0 && m_cnt == m_p) begin
            m_fp = 1;
            m_cnt = 0;
         end
      end
   endtask : step
   task automatic verify();
      logic [31:0] d;
      repeat (4) @(posedge clk_sys);
      rd(8'(PTM_OFS_COUNT_LOW), d);
      chk(d, 32'(m_cnt % 256));
      rd(8'(PTM_OFS_COUNT_HIGH), d);
      chk(d, 32'(m_cnt / 256));
      rd(PTM_OFS_FLAGS_FULL, d);
      chk(d, 32'(m_fp * 2 + m_fa));
      chk({30'h0, fp, fa}, 32'(m_fp * 2 + m_fa));
      chk({30'h0, t_inv, t_out}, ((m_pin ^ m_inv) == 1) ? 32'h1 : 32'h2);
   endtask : verify
   task automatic setup(input int k);
      m_io = int'(cfg_b[k][5:4]);
      m_lvl = int'(cfg_b[k][3]);
      m_inv = int'(cfg_b[k][2]);
      m_csel = int'(cfg_b[k][0]);
      m_a = cfg_a[k];
      m_p = cfg_p[k];
      wr(8'(PTM_OFS_CONTROL_A), 8'h00);
      wr(8'(PTM_OFS_CONTROL_B), cfg_b[k]);
      wr(8'(PTM_OFS_CMP_A_LOW), 8'(m_a));
      wr(8'(PTM_OFS_CMP_A_HIGH), 8'h00);
      wr(8'(PTM_OFS_PERIOD_LOW), 8'(m_p));
      wr(8'(PTM_OFS_PERIOD_HIGH), 8'h00);
      wr(PTM_OFS_FLAGS_FULL, 8'h03);
      m_fa = 0;
      m_fp = 0;
   endtask : setup
   initial begin
      logic [31:0] d;
      int n;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(8'(i * 4), d);
         chk(d, 32'h0);
      end
      rd(8'h24, d);
      chk(32'(rresp_seen), 32'(PTM_RESP_SLVERR));
      wr(8'h24, 8'h01);
      chk(32'(bresp_seen), 32'(PTM_RESP_SLVERR));
      wr(8'(PTM_OFS_CONTROL_A), 8'hff);
      rd(8'(PTM_OFS_CONTROL_A), d);
      chk(d, 32'hf8);
      wr(8'(PTM_OFS_CONTROL_A), 8'h00);
      wr(8'(PTM_OFS_CONTROL_B), 8'hfd);
      rd(8'(PTM_OFS_CONTROL_B), d);
      chk(d, 32'hfd);
      wr(8'(PTM_OFS_CMP_A_HIGH), 8'hff);
      rd(8'(PTM_OFS_CMP_A_HIGH), d);
      chk(d, 32'h3);
      wr(8'(PTM_OFS_COUNT_LOW), 8'hff);
      rd(8'(PTM_OFS_COUNT_LOW), d);
      chk(d, 32'h0);
      for (int k = 0; k < 5; k++) begin
         setup(k);
         wr(8'(PTM_OFS_CONTROL_A), {1'b0, cfg_s[k], 4'h8});
         m_cnt = 0;
         m_pin = m_lvl;
         verify();
         n = 1 + $unsigned($random(seed)) % 20;
         ptm_pin_model_i.pulses(n, 1 + lag());
         step(n);
         verify();
         wr(8'(PTM_OFS_CONTROL_A), {1'b1, cfg_s[k], 4'h8});
         ptm_pin_model_i.pulses(3, 1);
         verify();
         wr(8'(PTM_OFS_CONTROL_A), {1'b0, cfg_s[k], 4'h8});
         ptm_pin_model_i.pulses(2, 2);
         step(2);
         verify();
         wr(8'(PTM_OFS_CONTROL_A), {1'b0, cfg_s[k], 4'h0});
         ptm_pin_model_i.pulses(2, 1);
         verify();
      end
      // single pulse: pin edge starts the run, compare A ends it
      wr(8'(PTM_OFS_CONTROL_B), 8'hb8);
      wr(8'(PTM_OFS_CMP_A_LOW), 8'h03);
      wr(PTM_OFS_FLAGS_FULL, 8'h03);
      ptm_pin_model_i.pulses(1, 2);
      chk({30'h0, t_inv, t_out}, 32'h1);
      ptm_pin_model_i.pulses(3, 2);
      chk({30'h0, t_inv, t_out}, 32'h2);
      rd(8'(PTM_OFS_CONTROL_A), d);
      chk(d, 32'h60);
      rd(PTM_OFS_FLAGS_FULL, d);
      chk(d, 32'h1);
      rd(8'(PTM_OFS_COUNT_LOW), d);
      chk(d, 32'h3);
      // forced pin levels in pwm mode
      wr(8'(PTM_OFS_CONTROL_B), 8'h98);
      @(posedge clk_sys);
      chk({30'h0, t_inv, t_out}, 32'h1);
      wr(8'(PTM_OFS_CONTROL_B), 8'h88);
      @(posedge clk_sys);
      chk({30'h0, t_inv, t_out}, 32'h2);
      conclude();
   end
endmodule : testbench
